// File: pecc_regs.sv
// Error counters, PCS configuration and interrupt registers on AHB-Lite
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
// Notes on behaviour
// - False carrier count, bits 7:0, counts each false carrier, zeroed on read.
// - False carrier count sticks at FFh until a read clears it.
// - Receive error count, bits 7:0, counts carrier events with bad symbols, read clears.
// - Receive error count rises at most once per carrier event.
// - No receive error count for a carrier event that saw a collision.
// - Receive error count sticks at its top value until read.
// - Counter bits 15:8 and configuration bits 15:13 read zero, ignore writes.
// - Configuration bit 10, reset 0, selects true quiet transmit at 100 Mb/s.
// - Configuration bit 9, reset 0, forces signal detect.
// - Configuration bit 8, reset 1, selects enhanced signal detect algorithm.
// - Configuration bit 7, reset 0, descrambler timeout 2 ms when set, else 722 us.
// - Configuration bit 5, reset 0, forces good 100 Mb/s link.
// - Configuration bit 2, reset 0, bypasses NRZI coding.
module pecc_regs
   import pecc_pkg::*;
#(
   parameter int DESC_SHORT_CYCLES = PECC_DESC_SHORT_CYC,
   parameter int DESC_LONG_CYCLES  = PECC_DESC_LONG_CYC
)
(
   input  wire logic                   hclk,
   input  wire logic                   hresetn,
   input  wire logic                   hsel,
   input  wire logic [31:0]            haddr,
   input  wire logic [1:0]             htrans,
   input  wire logic                   hwrite,
   input  wire logic [2:0]             hsize,
   input  wire logic [31:0]            hwdata,
   input  wire logic                   hready,
   output logic                        hreadyout,
   output logic                        hresp,
   output logic [31:0]                 hrdata,
   input  wire logic                   false_carrier_event,
   input  wire logic                   carrier_valid,
   input  wire logic                   invalid_symbol,
   input  wire logic                   collision,
   output logic                        true_quiet_enable,
   output logic                        force_signal_detect,
   output logic                        enhanced_detect_select,
   output logic                        descrambler_timeout_long,
   output logic                        force_100_link_good,
   output logic                        nrzi_bypass,
   output logic [PECC_DESC_W-1:0]      descrambler_timeout_cycles,
   output logic                        irq
);

   ////////////////////////////////////////////////////////////////////////////////
   // Declarations

   logic                  addr_take;
   logic                  addr_mapped;
   logic [7:0]            addr_idx;
   logic                  rd_take;
   logic                  wr_pend;
   logic [7:0]            wr_idx;
   logic                  rd_pend;
   logic [7:0]            rd_idx;
   logic                  cfg_wr;
   logic                  mask_wr;
   logic [15:0]           cfg;
   logic [15:0]           cfg_view;
   logic [PECC_IRQ_W-1:0] irq_mask;
   logic [PECC_IRQ_W-1:0] mask_view;
   logic [PECC_IRQ_W-1:0] irq_status;
   logic [PECC_IRQ_W-1:0] irq_set;
   logic [PECC_IRQ_W-1:0] next_irq_status;
   logic                  fc_clear;
   logic                  rx_clear;
   logic                  status_clear;
   logic                  rx_error_event;
   logic [PECC_CNT_W-1:0] false_carrier_count;
   logic [PECC_CNT_W-1:0] receive_error_count;
   logic [31:0]           next_hrdata;

   ////////////////////////////////////////////////////////////////////////////////
   // Bus address phase

   // Only whole-word, aligned, low-page accesses hit a register
   assign addr_take   = hsel & htrans[1] & hready;
   assign addr_idx    = haddr[9:2];
   assign addr_mapped = (haddr[31:10] == 22'h000000) && (haddr[1:0] == 2'h0)
                        && (hsize == PECC_HSIZE_WORD);
   assign rd_take     = addr_take & ~hwrite;

   // Read side effects happen when the read is taken
   assign fc_clear     = rd_take & addr_mapped & (addr_idx == PECC_IDX_FALSE_CARRIER);
   assign rx_clear     = rd_take & addr_mapped & (addr_idx == PECC_IDX_RX_ERROR);
   assign status_clear = rd_take & addr_mapped & (addr_idx == PECC_IDX_IRQ_STATUS);

   // Remember a pending write for its data phase
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         wr_pend <= 1'b0;
         wr_idx  <= 8'h00;
      end
      else if (hready)
      begin
         wr_pend <= addr_take & hwrite & addr_mapped;
         wr_idx  <= addr_idx;
      end
   end

   // Read bookkeeping, used only by the checks below
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         rd_pend <= 1'b0;
         rd_idx  <= 8'h00;
      end
      else if (hready)
      begin
         rd_pend <= rd_take & addr_mapped;
         rd_idx  <= addr_idx;
      end
   end

   // Slave never stalls and always answers OKAY
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end
      else
      begin
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Configuration register

   assign cfg_wr  = wr_pend & (wr_idx == PECC_IDX_PCS_CFG);
   assign mask_wr = wr_pend & (wr_idx == PECC_IDX_IRQ_MASK);

   // Reserved bits are held at zero; software is expected to write zero
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         cfg <= PECC_CFG_RESET;
      else if (cfg_wr)
         cfg <= hwdata[15:0] & PECC_CFG_WRITABLE;
   end

   // Drive the PMA/PCS controls from the stored bits
   assign true_quiet_enable        = cfg[PECC_CFG_TRUE_QUIET];
   assign force_signal_detect      = cfg[PECC_CFG_FORCE_SD];
   assign enhanced_detect_select   = cfg[PECC_CFG_ENH_DETECT];
   assign descrambler_timeout_long = cfg[PECC_CFG_DESC_LONG];
   assign force_100_link_good      = cfg[PECC_CFG_FORCE_100];
   assign nrzi_bypass              = cfg[PECC_CFG_NRZI_BYPASS];

   // Timeout count for the descrambler, one cycle behind the bit
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         descrambler_timeout_cycles <= PECC_DESC_W'(DESC_SHORT_CYCLES);
      else if (cfg[PECC_CFG_DESC_LONG])
         descrambler_timeout_cycles <= PECC_DESC_W'(DESC_LONG_CYCLES);
      else
         descrambler_timeout_cycles <= PECC_DESC_W'(DESC_SHORT_CYCLES);
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Statistics counters

   pecc_sat_counter u_false_carrier
   (
      .hclk    (hclk),
      .hresetn (hresetn),
      .inc     (false_carrier_event),
      .clear   (fc_clear),
      .count   (false_carrier_count)
   );

   pecc_carrier_qual u_qual
   (
      .hclk           (hclk),
      .hresetn        (hresetn),
      .carrier_valid  (carrier_valid),
      .invalid_symbol (invalid_symbol),
      .collision      (collision),
      .error_event    (rx_error_event)
   );

   pecc_sat_counter u_rx_error
   (
      .hclk    (hclk),
      .hresetn (hresetn),
      .inc     (rx_error_event),
      .clear   (rx_clear),
      .count   (receive_error_count)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // Interrupts

   assign irq_set[PECC_IRQ_FALSE_CARRIER] = false_carrier_event;
   assign irq_set[PECC_IRQ_RX_ERROR]      = rx_error_event;

   // Sticky per bit; a new event beats the read that clears it
   genvar gi;
   generate
      for (gi = 0; gi < PECC_IRQ_W; gi = gi + 1)
      begin : g_irq
         assign next_irq_status[gi] = irq_set[gi] | (irq_status[gi] & ~status_clear);
      end
   endgenerate

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         irq_status <= PECC_IRQ_RESET;
      else
         irq_status <= next_irq_status;
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         irq_mask <= PECC_IRQ_RESET;
      else if (mask_wr)
         irq_mask <= hwdata[PECC_IRQ_W-1:0];
   end

   // Level output, one cycle behind the status bits
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         irq <= 1'b0;
      else
         irq <= |(irq_status & irq_mask);
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Read data

   // Forward a write still in its data phase so a read right after sees it
   assign cfg_view  = cfg_wr ? (hwdata[15:0] & PECC_CFG_WRITABLE) : cfg;
   assign mask_view = mask_wr ? hwdata[PECC_IRQ_W-1:0] : irq_mask;

   // Upper bits are always zero; unmapped reads return zero
   always_comb
   begin
      next_hrdata = 32'h00000000;
      if (rd_take && addr_mapped)
      begin
         unique case (addr_idx)
            PECC_IDX_FALSE_CARRIER: next_hrdata[PECC_CNT_W-1:0] = false_carrier_count;
            PECC_IDX_RX_ERROR:      next_hrdata[PECC_CNT_W-1:0] = receive_error_count;
            PECC_IDX_PCS_CFG:       next_hrdata[15:0]           = cfg_view;
            PECC_IDX_IRQ_STATUS:    next_hrdata[PECC_IRQ_W-1:0] = irq_status;
            PECC_IDX_IRQ_MASK:      next_hrdata[PECC_IRQ_W-1:0] = mask_view;
            default:                next_hrdata = 32'h00000000;
         endcase
      end
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         hrdata <= 32'h00000000;
      else if (hready)
         hrdata <= next_hrdata;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Checks

   property p_counter_upper_zero;
      @(posedge hclk) disable iff (!hresetn)
      rd_pend && (rd_idx == PECC_IDX_FALSE_CARRIER || rd_idx == PECC_IDX_RX_ERROR)
         |-> hrdata[31:8] == 24'h000000;
   endproperty
   a_counter_upper_zero: assert property (p_counter_upper_zero)
      else $error("Counter read returned nonzero upper bits");

   property p_fc_read_clears;
      @(posedge hclk) disable iff (!hresetn)
      (fc_clear && !false_carrier_event) |=> false_carrier_count == 8'h00;
   endproperty
   a_fc_read_clears: assert property (p_fc_read_clears)
      else $error("False carrier count not cleared by a read");

   property p_rx_read_clears;
      @(posedge hclk) disable iff (!hresetn)
      (rx_clear && !rx_error_event) |=> receive_error_count == 8'h00;
   endproperty
   a_rx_read_clears: assert property (p_rx_read_clears)
      else $error("Receive error count not cleared by a read");

   property p_true_quiet;
      @(posedge hclk) disable iff (!hresetn)
      cfg_wr |=> true_quiet_enable == $past(hwdata[PECC_CFG_TRUE_QUIET]);
   endproperty
   a_true_quiet: assert property (p_true_quiet)
      else $error("True quiet control does not follow the write");

   property p_force_sd;
      @(posedge hclk) disable iff (!hresetn)
      cfg_wr |=> force_signal_detect == $past(hwdata[PECC_CFG_FORCE_SD]);
   endproperty
   a_force_sd: assert property (p_force_sd)
      else $error("Signal detect force does not follow the write");

   property p_enh_detect;
      @(posedge hclk) disable iff (!hresetn)
      cfg_wr |=> enhanced_detect_select == $past(hwdata[PECC_CFG_ENH_DETECT]);
   endproperty
   a_enh_detect: assert property (p_enh_detect)
      else $error("Detect algorithm select does not follow the write");

   property p_desc_timeout;
      @(posedge hclk) disable iff (!hresetn)
      cfg_wr ##1 !cfg_wr |=> descrambler_timeout_cycles
         == ($past(hwdata[PECC_CFG_DESC_LONG], 2) ? PECC_DESC_W'(DESC_LONG_CYCLES)
                                 : PECC_DESC_W'(DESC_SHORT_CYCLES));
   endproperty
   a_desc_timeout: assert property (p_desc_timeout)
      else $error("Descrambler timeout count does not match its bit");

   property p_force_100;
      @(posedge hclk) disable iff (!hresetn)
      cfg_wr |=> force_100_link_good == $past(hwdata[PECC_CFG_FORCE_100]);
   endproperty
   a_force_100: assert property (p_force_100)
      else $error("Forced 100 link control does not follow the write");

   property p_nrzi;
      @(posedge hclk) disable iff (!hresetn)
      cfg_wr |=> nrzi_bypass == $past(hwdata[PECC_CFG_NRZI_BYPASS]);
   endproperty
   a_nrzi: assert property (p_nrzi)
      else $error("NRZI bypass control does not follow the write");
endmodule

// File: pecc_pkg.sv
// Constants for the transceiver error counter and PCS configuration registers
package pecc_pkg;

   // Register indices; byte address is four times the index
   localparam logic [7:0]  PECC_IDX_FALSE_CARRIER = 8'h14;
   localparam logic [7:0]  PECC_IDX_RX_ERROR      = 8'h15;
   localparam logic [7:0]  PECC_IDX_PCS_CFG       = 8'h16;
   localparam logic [7:0]  PECC_IDX_IRQ_STATUS    = 8'h1C;
   localparam logic [7:0]  PECC_IDX_IRQ_MASK      = 8'h1D;

   // Counter field
   localparam int          PECC_CNT_W             = 8;
   localparam logic [7:0]  PECC_CNT_RESET         = 8'h00;
   localparam logic [7:0]  PECC_CNT_MAX           = 8'hFF;

   // Configuration field positions
   localparam int          PECC_CFG_TRUE_QUIET    = 10;
   localparam int          PECC_CFG_FORCE_SD      = 9;
   localparam int          PECC_CFG_ENH_DETECT    = 8;
   localparam int          PECC_CFG_DESC_LONG     = 7;
   localparam int          PECC_CFG_FORCE_100     = 5;
   localparam int          PECC_CFG_NRZI_BYPASS   = 2;
   localparam logic [15:0] PECC_CFG_RESET         = 16'h0100;
   localparam logic [15:0] PECC_CFG_WRITABLE      = 16'h07A4;

   // Interrupt status and mask layout
   localparam int          PECC_IRQ_W             = 2;
   localparam int          PECC_IRQ_FALSE_CARRIER = 0;
   localparam int          PECC_IRQ_RX_ERROR      = 1;
   localparam logic [1:0]  PECC_IRQ_RESET         = 2'h0;

   // Descrambler loss-of-sync timeout
   localparam int          PECC_CLK_PERIOD_PS     = 20000;
   localparam int          PECC_DESC_SHORT_US     = 722;
   localparam int          PECC_DESC_LONG_MS      = 2;
   localparam int          PECC_DESC_SHORT_CYC    = PECC_DESC_SHORT_US * 1000000 / PECC_CLK_PERIOD_PS;
   localparam int          PECC_DESC_LONG_CYC     = PECC_DESC_LONG_MS * 1000000000 / PECC_CLK_PERIOD_PS;
   localparam int          PECC_DESC_W            = 17;

   // AHB encodings
   localparam logic [2:0]  PECC_HSIZE_WORD        = 3'h2;
endpackage

// File: pecc_sat_counter.sv
// Saturating clear-on-read event counter
`timescale 1ns/1ps
module pecc_sat_counter
   import pecc_pkg::*;
(
   input  wire logic                  hclk,
   input  wire logic                  hresetn,
   input  wire logic                  inc,
   input  wire logic                  clear,
   output logic [PECC_CNT_W-1:0]      count
);

   logic [PECC_CNT_W-1:0] base;

   // Clear and event in one cycle: the event still counts
   assign base = clear ? PECC_CNT_RESET : count;

   // Count up, stick at the top value
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         count <= PECC_CNT_RESET;
      else if (inc && base != PECC_CNT_MAX)
         count <= base + 8'h01;
      else
         count <= base;
   end

   property p_cnt_sticks;
      @(posedge hclk) disable iff (!hresetn)
      (count == PECC_CNT_MAX && !clear) |=> count == PECC_CNT_MAX;
   endproperty
   a_cnt_sticks: assert property (p_cnt_sticks)
      else $error("Counter left its top value without a clear");

   property p_cnt_steps;
      @(posedge hclk) disable iff (!hresetn)
      (inc && !clear && count != PECC_CNT_MAX) |=> count == $past(count) + 8'h01;
   endproperty
   a_cnt_steps: assert property (p_cnt_steps)
      else $error("Counter did not advance by one on an event");
endmodule

// File: pecc_carrier_qual.sv
// Qualifies symbol errors into one event per clean carrier event
`timescale 1ns/1ps
module pecc_carrier_qual
(
   input  wire logic hclk,
   input  wire logic hresetn,
   input  wire logic carrier_valid,
   input  wire logic invalid_symbol,
   input  wire logic collision,
   output logic      error_event
);

   logic seen_error;
   logic seen_collision;
   logic carrier_prev;
   logic events_in_gap;

   // Gather what happened inside the carrier event; restart at its end
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         seen_error     <= 1'b0;
         seen_collision <= 1'b0;
         carrier_prev   <= 1'b0;
      end
      else
      begin
         carrier_prev   <= carrier_valid;
         seen_error     <= carrier_valid & (seen_error | invalid_symbol);
         seen_collision <= carrier_valid & (seen_collision | collision);
      end
   end

   // Decide at the carrier's end so a late collision still vetoes
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         error_event <= 1'b0;
      else
         error_event <= carrier_prev & ~carrier_valid & seen_error & ~seen_collision;
   end

   // Check helper: an error event was already given since the last carrier start
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         events_in_gap <= 1'b0;
      else if (carrier_valid && !carrier_prev)
         events_in_gap <= 1'b0;
      else if (error_event)
         events_in_gap <= 1'b1;
   end

   property p_one_per_carrier;
      @(posedge hclk) disable iff (!hresetn)
      error_event |-> !events_in_gap;
   endproperty
   a_one_per_carrier: assert property (p_one_per_carrier)
      else $error("Two error events from one carrier event");

   property p_collision_veto;
      @(posedge hclk) disable iff (!hresetn)
      (carrier_prev && !carrier_valid && seen_collision) |=> !error_event;
   endproperty
   a_collision_veto: assert property (p_collision_veto)
      else $error("Error counted for a carrier event with a collision");
endmodule

// File: tb_top.sv
// Self-checking testbench for the error counter and PCS configuration registers
`timescale 1ns/1ps
module tb_top
   import pecc_pkg::*;
;
   localparam logic [31:0] A_FC  = {22'h0, PECC_IDX_FALSE_CARRIER, 2'b00};
   localparam logic [31:0] A_RX  = {22'h0, PECC_IDX_RX_ERROR, 2'b00};
   localparam logic [31:0] A_CFG = {22'h0, PECC_IDX_PCS_CFG, 2'b00};
   localparam logic [31:0] A_STS = {22'h0, PECC_IDX_IRQ_STATUS, 2'b00};
   localparam logic [31:0] A_MSK = {22'h0, PECC_IDX_IRQ_MASK, 2'b00};
   localparam int          SHORT = 40;
   localparam int          LONG  = 100;

   logic        hclk = 1'b0;
   logic        hresetn = 1'b0;
   logic        hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0]  htrans = 2'h0;
   logic        hwrite = 1'b0;
   logic [2:0]  hsize = PECC_HSIZE_WORD;
   logic [31:0] hwdata = 32'h0;
   logic        hreadyout, hresp, irq;
   logic [31:0] hrdata;
   logic        fce = 1'b0, cv = 1'b0, inv = 1'b0, col = 1'b0;
   logic        tq, fsd, enh, dlong, f100, nrzi;
   logic [PECC_DESC_W-1:0] dcyc;
   logic [31:0] rd, wd;
   int          failures = 0;
   int          total_checks = 0;
   int          fc_n, rx_n, ns;
   logic        cl;

   ////////////////////////////////////////////////////////////////////////////
   // Clock, reset and design
   initial
   begin
      forever #10 hclk = ~hclk;
   end

   pecc_regs #(.DESC_SHORT_CYCLES(SHORT), .DESC_LONG_CYCLES(LONG)) dut_u (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
      .false_carrier_event(fce), .carrier_valid(cv), .invalid_symbol(inv),
      .collision(col), .true_quiet_enable(tq), .force_signal_detect(fsd),
      .enhanced_detect_select(enh), .descrambler_timeout_long(dlong),
      .force_100_link_good(f100), .nrzi_bypass(nrzi),
      .descrambler_timeout_cycles(dcyc), .irq(irq));

   ////////////////////////////////////////////////////////////////////////////
   // Expectations and checking
   function automatic logic [31:0] sat(input int n);
      return (n > 255) ? 32'h0000_00FF : 32'(n);
   endfunction

   // Only the six control bits survive a write
   function automatic logic [31:0] cfg_exp(input logic [31:0] w);
      logic [31:0] e;
      e = 32'h0;
      e[PECC_CFG_TRUE_QUIET]  = w[PECC_CFG_TRUE_QUIET];
      e[PECC_CFG_FORCE_SD]    = w[PECC_CFG_FORCE_SD];
      e[PECC_CFG_ENH_DETECT]  = w[PECC_CFG_ENH_DETECT];
      e[PECC_CFG_DESC_LONG]   = w[PECC_CFG_DESC_LONG];
      e[PECC_CFG_FORCE_100]   = w[PECC_CFG_FORCE_100];
      e[PECC_CFG_NRZI_BYPASS] = w[PECC_CFG_NRZI_BYPASS];
      return e;
   endfunction

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
      total_checks++;
      if (seen !== exp)
      begin
         failures++;
         $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, msg, seen, exp);
      end
   endtask

   task automatic give_verdict();
      $display("checks %0d mismatches %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // Bus and event drivers
   // Address phase held until hready, then data phase held until hready
   task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] w,
                      output logic [31:0] r);
      @(posedge hclk);
      hsel   <= 1'b1;
      haddr  <= a;
      htrans <= 2'b10;
      hwrite <= wr;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      hsel   <= 1'b0;
      htrans <= 2'b00;
      hwdata <= w;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      r = hrdata;
   endtask

   task automatic rchk(input logic [31:0] a, input logic [31:0] exp, input string msg);
      logic [31:0] r;
      bus(1'b0, a, 32'h0, r);
      chk(r, exp, msg);
      chk({31'h0, hresp}, 32'h0, "hresp okay");
   endtask

   // Each high cycle is one false carrier
   task automatic fc_pulses(input int n);
      repeat (n)
      begin
         @(posedge hclk);
         fce <= 1'b1;
      end
      @(posedge hclk);
      fce <= 1'b0;
   endtask

   // One carrier event with nsym bad symbols and an optional collision
   task automatic carrier(input int nsym, input logic coll);
      int cpos;
      cpos = $urandom_range(5);
      @(posedge hclk);
      cv <= 1'b1;
      for (int i = 0; i < 6; i++)
      begin
         @(posedge hclk);
         inv <= (i < nsym);
         col <= coll && (i == cpos);
      end
      @(posedge hclk);
      cv  <= 1'b0;
      inv <= 1'b0;
      col <= 1'b0;
      repeat (3) @(posedge hclk);
      if (nsym > 0 && !coll)
         rx_n++;
   endtask

   task automatic end_test(input string name);
      $display("test %s done", name);
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // Watchdog, sized well above the few thousand cycles the tests need
   initial
   begin
      repeat (50000) @(posedge hclk);
      failures++;
      give_verdict();
   end

   ////////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial
   begin
      void'($urandom(78632));
      repeat (4) @(posedge hclk);
      hresetn <= 1'b1;
      // Reset values
      chk({31'h0, irq}, 32'h0, "irq at reset");
      chk({26'h0, tq, fsd, enh, dlong, f100, nrzi}, 32'h08, "cfg outputs");
      chk(32'(dcyc), SHORT, "short timeout");
      rchk(A_FC, 32'h0, "fc reset");
      rchk(A_RX, 32'h0, "rx reset");
      rchk(A_CFG, 32'h0000_0100, "cfg reset");
      rchk(A_MSK, 32'h0, "mask reset");
      end_test("reset");
      // Configuration: corners then random words, reserved bits must not stick
      for (int k = 0; k < 8; k++)
      begin
         wd = ((k == 0) ? 32'hFFFF_FFFF : (k == 1) ? 32'h0 : $urandom) & 32'hFFFF_E7A6;
         bus(1'b1, A_CFG, wd, rd);
         rchk(A_CFG, cfg_exp(wd), "cfg readback");
         chk({31'h0, tq}, {31'h0, wd[PECC_CFG_TRUE_QUIET]}, "true quiet");
         chk({31'h0, fsd}, {31'h0, wd[PECC_CFG_FORCE_SD]}, "force sd");
         chk({31'h0, enh}, {31'h0, wd[PECC_CFG_ENH_DETECT]}, "enh detect");
         chk({31'h0, dlong}, {31'h0, wd[PECC_CFG_DESC_LONG]}, "desc long");
         chk(32'(dcyc), wd[PECC_CFG_DESC_LONG] ? LONG : SHORT, "desc cycles");
         chk({31'h0, f100}, {31'h0, wd[PECC_CFG_FORCE_100]}, "force 100");
         chk({31'h0, nrzi}, {31'h0, wd[PECC_CFG_NRZI_BYPASS]}, "nrzi");
      end
      bus(1'b1, A_CFG, 32'h0000_0100, rd); // Reserved bits written as zero
      end_test("config");
      // False carrier count ignores writes; unmapped space reads zero
      bus(1'b1, A_FC, 32'hFFFF_FFFF, rd);
      rchk(A_FC, 32'h0, "fc write ignored");
      bus(1'b1, 32'h0000_005C, 32'hFFFF_FFFF, rd);
      rchk(32'h0000_005C, 32'h0, "unmapped");
      end_test("readonly");
      // False carrier counting, clear on read, saturation
      fc_n = $urandom_range(200, 1);
      fc_pulses(fc_n);
      rchk(A_FC, sat(fc_n), "fc count");
      rchk(A_FC, 32'h0, "fc cleared");
      fc_pulses(300);
      rchk(A_FC, 32'h0000_00FF, "fc saturated");
      rchk(A_FC, 32'h0, "fc cleared after sat");
      end_test("false_carrier");
      // Receive errors: one per event, none with collision or no bad symbol
      rx_n = 0;
      carrier(6, 1'b0);
      carrier(1, 1'b1);
      carrier(0, 1'b0);
      rchk(A_RX, 32'h1, "rx once per event");
      rx_n = 0;
      for (int k = 0; k < 30; k++)
      begin
         ns = $urandom_range(6);
         cl = $urandom_range(3) == 0;
         carrier(ns, cl);
      end
      rchk(A_RX, sat(rx_n), "rx random");
      rchk(A_RX, 32'h0, "rx cleared");
      rx_n = 0;
      repeat (260) carrier(2, 1'b0);
      rchk(A_RX, sat(rx_n), "rx saturated");
      rchk(A_RX, 32'h0, "rx cleared after sat");
      end_test("receive_error");
      // Interrupt: raise, clear by status read, mask
      bus(1'b0, A_STS, 32'h0, rd);
      bus(1'b1, A_MSK, 32'h1, rd);
      fc_pulses(1);
      repeat (3) @(posedge hclk);
      chk({31'h0, irq}, 32'h1, "irq raised");
      rchk(A_STS, 32'h1, "status fc");
      repeat (2) @(posedge hclk);
      chk({31'h0, irq}, 32'h0, "irq cleared");
      carrier(3, 1'b0);
      repeat (3) @(posedge hclk);
      chk({31'h0, irq}, 32'h0, "irq masked");
      bus(1'b1, A_MSK, 32'h2, rd);
      repeat (3) @(posedge hclk);
      chk({31'h0, irq}, 32'h1, "irq unmasked rx");
      rchk(A_STS, 32'h2, "status rx");
      repeat (2) @(posedge hclk);
      chk({31'h0, irq}, 32'h0, "irq rx cleared");
      rchk(A_RX, 32'h1, "rx after irq");
      end_test("interrupt");
      give_verdict();
   end
endmodule
